/* File: common/sto_if.sv */
`timescale 1ns/1ps
interface sto_if;
    logic ch_a;
    logic ch_b;
    logic clear_rise;
    logic alarm_reset_rise;
    logic ms_tick;
    modport sync (output ch_a, output ch_b, output clear_rise, output alarm_reset_rise);
    modport tick (output ms_tick);
    modport core (input ch_a, input ch_b, input clear_rise, input alarm_reset_rise,
                  input ms_tick);
endinterface : sto_if

/* File: common/sto_pkg.sv */
package sto_pkg;
    typedef enum logic [1:0] {
        STO_RUN = 2'b00,
        STO_OFF = 2'b01,
        STO_WAIT_CLEAR = 2'b10,
        STO_SHUTDOWN = 2'b11
    } sto_state_t;
endpackage : sto_pkg

/* File: common/sto_regs.svh */
`ifndef STO_REGS_SVH
`define STO_REGS_SVH

// Register byte offsets on the Avalon-MM slave.
`define STO_OFS_CTRL 4'h0
`define STO_OFS_STATUS 4'h4
`define STO_OFS_IRQ_STATUS 4'h8
`define STO_OFS_IRQ_MASK 4'hc

// Control register fields.
`define STO_CTRL_MODE_BIT 0
`define STO_CTRL_DELAY_LSB 8
`define STO_CTRL_DELAY_MSB 15
`define STO_CTRL_RESET 32'h0000_0000

// Status register fields.
`define STO_ST_CH_A_BIT 0
`define STO_ST_CH_B_BIT 1
`define STO_ST_FEEDBACK_BIT 2
`define STO_ST_REMOVED_BIT 3
`define STO_ST_LATCHED_BIT 4
`define STO_ST_MISMATCH_ALM_BIT 5
`define STO_ST_SHUTDOWN_ALM_BIT 6
`define STO_ST_EXCITED_BIT 7

// Interrupt status and mask fields.
`define STO_IRQ_WIDTH 3
`define STO_IRQ_TORQUE_OFF_BIT 0
`define STO_IRQ_MISMATCH_BIT 1
`define STO_IRQ_RESTORED_BIT 2
`define STO_IRQ_RESET 3'h0

// Mode selection codes.
`define STO_MODE_LATCHED 1'h0
`define STO_MODE_SHUTDOWN 1'h1

// Dual-channel check delay window in milliseconds.
`define STO_DELAY_MIN_MS 8'h0b
`define STO_DELAY_MAX_MS 8'h64

// Timing: clock period, millisecond tick, indicator blink half period.
`define STO_CLK_PERIOD_PS 4000
`define STO_TICK_NS 1000000
`define STO_TICK_CYCLES ((`STO_TICK_NS * 1000) / `STO_CLK_PERIOD_PS)
`define STO_BLINK_HALF_MS 8'hfa

`endif

/* File: core/sto_sync.sv */
`timescale 1ns/1ps
module sto_sync (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Pins
    input wire logic shutoff_channel_a_in,
    input wire logic shutoff_channel_b_in,
    input wire logic torque_off_latch_clear_in,
    input wire logic alarm_reset_input_in,
    // Synchronised levels and edges
    sto_if.sync sig
);
    logic [3:0] stage1;
    logic [3:0] stage2;
    logic [1:0] prev;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1 <= 4'h0;
            stage2 <= 4'h0;
        end else begin
            stage1 <= {alarm_reset_input_in, torque_off_latch_clear_in,
                       shutoff_channel_b_in, shutoff_channel_a_in};
            stage2 <= stage1;
        end
    end

    // Edges are taken from the second stage only.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev <= 2'h0;
        end else begin
            prev <= stage2[3:2];
        end
    end

    assign sig.ch_a = stage2[0];
    assign sig.ch_b = stage2[1];
    assign sig.clear_rise = stage2[2] & ~prev[0];
    assign sig.alarm_reset_rise = stage2[3] & ~prev[1];
endmodule : sto_sync

/* File: core/sto_tick.sv */
`timescale 1ns/1ps
module sto_tick #(
    parameter int unsigned TICK_CYCLES = 250000
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Millisecond enable
    sto_if.tick tk
);
    logic [31:0] count;
    logic pulse;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count <= 32'h0;
            pulse <= 1'b0;
        end else if (count == 32'(TICK_CYCLES - 1)) begin
            count <= 32'h0;
            pulse <= 1'b1;
        end else begin
            count <= count + 32'h1;
            pulse <= 1'b0;
        end
    end

    assign tk.ms_tick = pulse;
endmodule : sto_tick

/* File: core/sto_top.sv */
// Behaviour
// - Either channel off cuts motor power
// - Power cut ignores free-run and commands
// - Indicator blinks green while torque removed; the code keeps green off while an alarm shows red
// - Both on: feedback off, normal, excitation allowed
// - One off: feedback off, non-excited, alarm
// - Mismatch alarm only with 11-100 ms delay
// - Both off: feedback on, latch or shutdown
// - Latch clears on clear edge, channels on
// - Shutdown clears on alarm-reset rising edge
// - Latch clear with command re-excites, ready
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "sto_regs.svh"
module sto_top
    import sto_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `STO_TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Safety connector pins
    input wire logic shutoff_channel_a_in,
    input wire logic shutoff_channel_b_in,
    input wire logic torque_off_latch_clear_in,
    input wire logic alarm_reset_input_in,
    output logic torque_off_feedback_out,
    // Drive control from the motion logic
    input wire logic excite_cmd_in,
    input wire logic free_run_in,
    // Power stage and status
    output logic external_torque_removal_out,
    output logic motor_excite_out,
    output logic ready_out,
    output logic drive_command_ready_out,
    output logic power_alarm_indicator_green_out,
    output logic power_alarm_indicator_red_out,
    output logic irq_out,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    function automatic logic delay_in_window(input logic [7:0] d);
        delay_in_window = (d >= `STO_DELAY_MIN_MS) && (d <= `STO_DELAY_MAX_MS);
    endfunction : delay_in_window

    sto_if sig ();

    sto_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .shutoff_channel_a_in(shutoff_channel_a_in),
        .shutoff_channel_b_in(shutoff_channel_b_in),
        .torque_off_latch_clear_in(torque_off_latch_clear_in),
        .alarm_reset_input_in(alarm_reset_input_in),
        .sig(sig.sync)
    );

    sto_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .tk(sig.tick)
    );

    logic mode_shutdown;
    logic [7:0] check_delay_ms;
    sto_state_t state;
    sto_state_t next_state;
    logic [7:0] mismatch_ms;
    logic mismatch_alarm;
    logic [7:0] blink_ms;
    logic blink_phase;
    logic [`STO_IRQ_WIDTH-1:0] irq_status;
    logic [`STO_IRQ_WIDTH-1:0] irq_mask;
    logic [`STO_IRQ_WIDTH-1:0] irq_events;
    logic both_on;
    logic both_off;
    logic one_off;
    logic any_alarm;
    logic excite_ok;
    logic [1:0] sync_fill;
    logic bus_req;
    logic bus_take;
    logic [31:0] status_word;
    logic [31:0] next_readdata;

    assign both_on = sig.ch_a & sig.ch_b;
    assign both_off = ~sig.ch_a & ~sig.ch_b;
    assign one_off = sig.ch_a ^ sig.ch_b;
    assign any_alarm = mismatch_alarm | (state == STO_SHUTDOWN);

    // Excitation needs both channels on, a running state, no alarm and a command.
    assign excite_ok = both_on && (state == STO_RUN) && !any_alarm
                       && excite_cmd_in && !free_run_in;

    // The synchroniser resets to channels off; nothing latches until it holds the pins.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_fill <= 2'h0;
        end else if (!sync_fill[1]) begin
            sync_fill <= sync_fill + 2'h1;
        end
    end

    // Power removal depends on the channels alone, so no command path can hold it off.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            external_torque_removal_out <= 1'b1;
        end else begin
            external_torque_removal_out <= ~both_on;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            torque_off_feedback_out <= 1'b0;
        end else begin
            torque_off_feedback_out <= both_off & sync_fill[1];
        end
    end

    // Torque-off state; a mismatch alone removes power but does not latch.
    always_comb begin
        next_state = state;
        unique case (state)
            STO_RUN: begin
                if (both_off && sync_fill[1]) begin
                    next_state = mode_shutdown ? STO_SHUTDOWN : STO_OFF;
                end
            end
            STO_OFF: begin
                if (both_on) begin
                    next_state = STO_WAIT_CLEAR;
                end
            end
            STO_WAIT_CLEAR: begin
                if (both_off) begin
                    next_state = STO_OFF;
                end else if (sig.clear_rise && both_on && !mismatch_alarm) begin
                    next_state = STO_RUN;
                end
            end
            STO_SHUTDOWN: begin
                if (sig.alarm_reset_rise && !both_off) begin
                    next_state = STO_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= STO_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Mismatch time is counted in whole milliseconds.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mismatch_ms <= 8'h0;
        end else if (!one_off) begin
            mismatch_ms <= 8'h0;
        end else if (sig.ms_tick && mismatch_ms != 8'hff) begin
            mismatch_ms <= mismatch_ms + 8'h1;
        end
    end

    // The alarm holds until an alarm reset arrives with the mismatch gone.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mismatch_alarm <= 1'b0;
        end else if (one_off && delay_in_window(check_delay_ms)
                     && mismatch_ms >= check_delay_ms) begin
            mismatch_alarm <= 1'b1;
        end else if (sig.alarm_reset_rise && !one_off) begin
            mismatch_alarm <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            motor_excite_out <= 1'b0;
            ready_out <= 1'b0;
            drive_command_ready_out <= 1'b0;
        end else begin
            motor_excite_out <= excite_ok;
            ready_out <= excite_ok;
            drive_command_ready_out <= excite_ok;
        end
    end

    // Indicator blink timebase.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            blink_ms <= 8'h0;
            blink_phase <= 1'b0;
        end else if (sig.ms_tick) begin
            if (blink_ms == `STO_BLINK_HALF_MS - 8'h1) begin
                blink_ms <= 8'h0;
                blink_phase <= ~blink_phase;
            end else begin
                blink_ms <= blink_ms + 8'h1;
            end
        end
    end

    // Alarms show red; torque removal without an alarm blinks green.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            power_alarm_indicator_green_out <= 1'b0;
            power_alarm_indicator_red_out <= 1'b0;
        end else begin
            power_alarm_indicator_red_out <= any_alarm;
            if (any_alarm) begin
                power_alarm_indicator_green_out <= 1'b0;
            end else if (!both_on || state != STO_RUN) begin
                power_alarm_indicator_green_out <= blink_phase;
            end else begin
                power_alarm_indicator_green_out <= 1'b1;
            end
        end
    end

    // Bus: one wait state, then the request is taken at the edge with waitrequest low.
    assign bus_req = avs_read_in | avs_write_in;
    assign bus_take = bus_req & ~avs_waitrequest_out;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_shutdown <= `STO_MODE_LATCHED;
            check_delay_ms <= 8'h0;
        end else if (bus_take && avs_write_in && avs_address_in == `STO_OFS_CTRL) begin
            if (avs_byteenable_in[0]) begin
                mode_shutdown <= avs_writedata_in[`STO_CTRL_MODE_BIT];
            end
            if (avs_byteenable_in[1]) begin
                check_delay_ms <= avs_writedata_in[`STO_CTRL_DELAY_MSB:`STO_CTRL_DELAY_LSB];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_mask <= `STO_IRQ_RESET;
        end else if (bus_take && avs_write_in && avs_address_in == `STO_OFS_IRQ_MASK
                     && avs_byteenable_in[0]) begin
            irq_mask <= avs_writedata_in[`STO_IRQ_WIDTH-1:0];
        end
    end

    always_comb begin
        irq_events = `STO_IRQ_RESET;
        irq_events[`STO_IRQ_TORQUE_OFF_BIT] = (state == STO_RUN) && both_off && sync_fill[1];
        irq_events[`STO_IRQ_MISMATCH_BIT] = one_off && !mismatch_alarm
                                            && delay_in_window(check_delay_ms)
                                            && mismatch_ms >= check_delay_ms;
        irq_events[`STO_IRQ_RESTORED_BIT] = (state != STO_RUN) && (next_state == STO_RUN);
    end

    // A read clears the status, but an event in the same cycle survives.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_status <= `STO_IRQ_RESET;
        end else if (bus_take && avs_read_in && avs_address_in == `STO_OFS_IRQ_STATUS) begin
            irq_status <= irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |((irq_status | irq_events) & irq_mask);
        end
    end

    always_comb begin
        status_word = 32'h0;
        status_word[`STO_ST_CH_A_BIT] = sig.ch_a;
        status_word[`STO_ST_CH_B_BIT] = sig.ch_b;
        status_word[`STO_ST_FEEDBACK_BIT] = torque_off_feedback_out;
        status_word[`STO_ST_REMOVED_BIT] = external_torque_removal_out;
        status_word[`STO_ST_LATCHED_BIT] = (state == STO_OFF) || (state == STO_WAIT_CLEAR);
        status_word[`STO_ST_MISMATCH_ALM_BIT] = mismatch_alarm;
        status_word[`STO_ST_SHUTDOWN_ALM_BIT] = (state == STO_SHUTDOWN);
        status_word[`STO_ST_EXCITED_BIT] = motor_excite_out;
    end

    always_comb begin
        next_readdata = 32'h0;
        unique case (avs_address_in)
            `STO_OFS_CTRL: begin
                next_readdata[`STO_CTRL_MODE_BIT] = mode_shutdown;
                next_readdata[`STO_CTRL_DELAY_MSB:`STO_CTRL_DELAY_LSB] = check_delay_ms;
            end
            `STO_OFS_STATUS: next_readdata = status_word;
            `STO_OFS_IRQ_STATUS: next_readdata[`STO_IRQ_WIDTH-1:0] = irq_status;
            `STO_OFS_IRQ_MASK: next_readdata[`STO_IRQ_WIDTH-1:0] = irq_mask;
            default: next_readdata = 32'h0;
        endcase
    end

    // Read data is captured in the wait cycle and stands at the taking edge.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_readdata_out <= 32'h0;
        end else if (avs_read_in && avs_waitrequest_out) begin
            avs_readdata_out <= next_readdata;
        end
    end
endmodule : sto_top

/* File: sim/sto_contacts.sv */
`timescale 1ns/1ps
module sto_contacts (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Contact commands and feedback
    input wire logic open_a_in,
    input wire logic open_b_in,
    input wire logic feedback_in,
    // Channel wiring and monitor verdict
    output logic channel_a_out,
    output logic channel_b_out,
    output logic fault_out
);
    logic [2:0] bad;
    // Each channel has its own contact, so one stuck contact cannot hold both.
    assign channel_a_out = !open_a_in;
    assign channel_b_out = !open_b_in;
    // The feedback lags the pins by the synchroniser, so brief disagreement is allowed.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bad <= 3'h0;
            fault_out <= 1'b0;
        end else begin
            if (feedback_in == (channel_a_out || channel_b_out)) begin
                bad <= (bad == 3'h7) ? bad : bad + 3'h1;
            end else begin
                bad <= 3'h0;
            end
            if (bad == 3'h6) begin
                fault_out <= 1'b1;
            end
        end
    end
endmodule : sto_contacts

/* File: sim/sto_top_sva.sv */
`timescale 1ns/1ps
module sto_top_sva #(
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Pins and commands
    input wire logic shutoff_channel_a_in,
    input wire logic shutoff_channel_b_in,
    input wire logic free_run_in,
    // Outputs
    input wire logic torque_off_feedback_out,
    input wire logic external_torque_removal_out,
    input wire logic motor_excite_out,
    input wire logic ready_out,
    input wire logic drive_command_ready_out,
    input wire logic power_alarm_indicator_green_out,
    input wire logic power_alarm_indicator_red_out
);
    // One spare tick allows for the tick phase when blinking starts.
    localparam int unsigned BLINK_MAX = 251 * TICK_CYCLES + 8;
    logic [2:0] live;
    logic green_q;
    int unsigned still;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // The pin history is trusted only once the synchroniser holds post-reset values.
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            live <= 3'h0;
        end else if (live != 3'h7) begin
            live <= live + 3'h1;
        end
    end
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            green_q <= 1'b0;
            still <= 0;
        end else begin
            green_q <= power_alarm_indicator_green_out;
            if (!external_torque_removal_out || power_alarm_indicator_red_out
                || power_alarm_indicator_green_out != green_q) begin
                still <= 0;
            end else begin
                still <= still + 1;
            end
        end
    end
    cut_when_off_a: assert property (
        live == 3'h7 && !(shutoff_channel_a_in && shutoff_channel_b_in)
        |-> ##3 external_torque_removal_out)
        else $error("power not cut after a channel went off");
    excite_safe_a: assert property (
        motor_excite_out |-> !external_torque_removal_out && !torque_off_feedback_out)
        else $error("motor excited while power is cut");
    feedback_pins_a: assert property (
        live == 3'h7 |-> torque_off_feedback_out
        == (!$past(shutoff_channel_a_in, 3) && !$past(shutoff_channel_b_in, 3)))
        else $error("feedback does not match both channels off");
    fb_removal_a: assert property (
        torque_off_feedback_out |-> external_torque_removal_out)
        else $error("feedback high without power cut");
    ready_follow_a: assert property (
        ready_out == motor_excite_out && drive_command_ready_out == motor_excite_out)
        else $error("ready outputs differ from excitation");
    free_run_a: assert property (
        free_run_in ##1 free_run_in |-> !motor_excite_out)
        else $error("excited during free run");
    alarm_led_a: assert property (
        power_alarm_indicator_red_out |-> !power_alarm_indicator_green_out)
        else $error("green lit during alarm");
    green_blink_a: assert property (
        still <= BLINK_MAX)
        else $error("green stopped blinking while power cut");
endmodule : sto_top_sva

/* File: sim/tb_safe_torque_off_monitor.sv */
`timescale 1ns/1ps
`include "sto_regs.svh"
module tb_safe_torque_off_monitor;
    import sto_pkg::*;
    localparam int unsigned TICK = 10;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic op_a = 1'b0, op_b = 1'b0, clr = 1'b0, arst = 1'b0, exc = 1'b1, frun = 1'b0;
    logic rd = 1'b0, wr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic ch_a, ch_b, fault, fb, rem, exo, rdy, dcr, grn, red, irq, wreq;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] dly [3] = '{8'h00, 8'h0a, 8'h65};
    always #2 ref_clk_in = ~ref_clk_in;
    sto_contacts peer (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .open_a_in(op_a),
        .open_b_in(op_b), .feedback_in(fb), .channel_a_out(ch_a), .channel_b_out(ch_b),
        .fault_out(fault));
    sto_top #(.TICK_CYCLES(TICK)) dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .shutoff_channel_a_in(ch_a), .shutoff_channel_b_in(ch_b),
        .torque_off_latch_clear_in(clr), .alarm_reset_input_in(arst),
        .torque_off_feedback_out(fb), .excite_cmd_in(exc), .free_run_in(frun),
        .external_torque_removal_out(rem), .motor_excite_out(exo), .ready_out(rdy),
        .drive_command_ready_out(dcr), .power_alarm_indicator_green_out(grn),
        .power_alarm_indicator_red_out(red), .irq_out(irq), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq));
    task results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            results;
        end
    end
    task chk_pin(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_pin
    task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg
    task tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : tick
    // Checks run at the falling edge, after every output of the rising edge has landed.
    task wait_pins(input logic a, input logic b, input int n);
        @(posedge ref_clk_in);
        op_a <= a;
        op_b <= b;
        tick(n);
        @(negedge ref_clk_in);
    endtask : wait_pins
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        // Only the bench timeout ends a wait that never gets an answer.
        do begin
            @(posedge ref_clk_in);
        end while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk_reg(nm, e, q);
    endtask : rd_chk
    task pulse(input logic alarm);
        @(posedge ref_clk_in);
        if (alarm) arst <= 1'b1;
        else clr <= 1'b1;
        tick(6);
        arst <= 1'b0;
        clr <= 1'b0;
        tick(6);
        @(negedge ref_clk_in);
    endtask : pulse
    task blink;
        logic g;
        int n;
        g = grn;
        n = 0;
        while (grn === g && n < 251 * TICK + 20) begin
            @(posedge ref_clk_in);
            n++;
        end
        chk_pin("green toggle", !g, grn);
    endtask : blink
    task t_run;
        chk_pin("removal", 1'b0, rem);
        chk_pin("excite", 1'b1, exo);
        chk_pin("feedback", 1'b0, fb);
        chk_pin("green", 1'b1, grn);
        rd_chk("ctrl", `STO_OFS_CTRL, `STO_CTRL_RESET);
        rd_chk("status", `STO_OFS_STATUS, 32'h83);
        rd_chk("unmapped", 4'h2, 32'h0);
        rd_chk("mask", `STO_OFS_IRQ_MASK, 32'h0);
        @(posedge ref_clk_in);
        frun <= 1'b1;
        wait_pins(1'b0, 1'b0, 4);
        chk_pin("free excite", 1'b0, exo);
        chk_pin("free removal", 1'b0, rem);
        @(posedge ref_clk_in);
        frun <= 1'b0;
        wait_pins(1'b0, 1'b0, 4);
        chk_pin("resume", 1'b1, exo);
    endtask : t_run
    task t_latched;
        bus(1'b1, `STO_OFS_IRQ_MASK, 32'h7);
        wait_pins(1'b1, 1'b1, 6);
        chk_pin("feedback", 1'b1, fb);
        chk_pin("removal", 1'b1, rem);
        chk_pin("irq", 1'b1, irq);
        rd_chk("status", `STO_OFS_STATUS, 32'h1c);
        rd_chk("irq status", `STO_OFS_IRQ_STATUS, 32'h1);
        tick(1);
        @(negedge ref_clk_in);
        chk_pin("irq clear", 1'b0, irq);
        blink;
        blink;
        pulse(1'b0);
        chk_pin("clear refused", 1'b0, exo);
        wait_pins(1'b0, 1'b0, 6);
        chk_pin("still latched", 1'b0, exo);
        pulse(1'b0);
        chk_pin("excite", 1'b1, exo);
        chk_pin("ready", 1'b1, rdy);
        chk_pin("cmd ready", 1'b1, dcr);
        rd_chk("restored", `STO_OFS_IRQ_STATUS, 32'h4);
    endtask : t_latched
    task t_mismatch;
        foreach (dly[i]) begin
            bus(1'b1, `STO_OFS_CTRL, {16'h0, dly[i], 8'h0});
            wait_pins(1'b0, 1'b1, 120 * TICK);
            chk_pin("no alarm", 1'b0, red);
            chk_pin("one off excite", 1'b0, exo);
            wait_pins(1'b0, 1'b0, 6);
            pulse(1'b0);
        end
        bus(1'b1, `STO_OFS_CTRL, 32'h0b00);
        wait_pins(1'b1, 1'b1, 6);
        wait_pins(1'b0, 1'b1, 10 * TICK);
        chk_pin("early alarm", 1'b0, red);
        wait_pins(1'b0, 1'b1, 3 * TICK + 8);
        chk_pin("alarm", 1'b1, red);
        rd_chk("irq mismatch", `STO_OFS_IRQ_STATUS, 32'h3);
        chk_pin("feedback", 1'b0, fb);
        wait_pins(1'b0, 1'b0, 6);
        pulse(1'b0);
        chk_pin("clear in alarm", 1'b0, exo);
        pulse(1'b1);
        chk_pin("alarm reset", 1'b0, red);
        pulse(1'b0);
        chk_pin("excite", 1'b1, exo);
    endtask : t_mismatch
    task t_shutdown;
        bus(1'b1, `STO_OFS_CTRL, 32'h1);
        wait_pins(1'b1, 1'b1, 6);
        chk_pin("feedback", 1'b1, fb);
        chk_pin("shutdown alarm", 1'b1, red);
        rd_chk("shutdown status", `STO_OFS_STATUS, 32'h4c);
        wait_pins(1'b0, 1'b0, 6);
        pulse(1'b0);
        chk_pin("clear ignored", 1'b0, exo);
        pulse(1'b1);
        chk_pin("excite", 1'b1, exo);
        chk_pin("alarm off", 1'b0, red);
    endtask : t_shutdown
    initial begin
        tick(15);
        @(negedge ref_clk_in);
        chk_pin("reset removal", 1'b1, rem);
        chk_pin("reset wait", 1'b1, wreq);
        chk_pin("reset excite", 1'b0, exo);
        @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        wait_pins(1'b0, 1'b0, 10);
        t_run;
        t_latched;
        t_mismatch;
        t_shutdown;
        chk_pin("monitor fault", 1'b0, fault);
        results;
    end
endmodule : tb_safe_torque_off_monitor
bind sto_top sto_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .shutoff_channel_a_in(shutoff_channel_a_in),
    .shutoff_channel_b_in(shutoff_channel_b_in), .free_run_in(free_run_in),
    .torque_off_feedback_out(torque_off_feedback_out),
    .external_torque_removal_out(external_torque_removal_out),
    .motor_excite_out(motor_excite_out), .ready_out(ready_out),
    .drive_command_ready_out(drive_command_ready_out),
    .power_alarm_indicator_green_out(power_alarm_indicator_green_out),
    .power_alarm_indicator_red_out(power_alarm_indicator_red_out));
